//--- timer_watchdog_unit.sv
// Timer and watchdog unit: prescaler, periodic timer, watchdog, locks and register port
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
module timer_watchdog_unit
  import twu_pkg::*;
(
  input wire logic i_mclk,                  // System clock, 100 MHz
  input wire logic i_reset,                 // Core domain reset, sync, active high
  input wire logic i_por_reset,             // Power-on reset, sync, active high
  input wire logic i_low_freq_clock,        // 32.768 kHz clock pin, asynchronous
  input wire twu_bus_req_t i_bus,           // Register request
  output logic [15:0] o_rdata,              // Read data, cycle after read strobe
  output logic o_timer_terminal_pulse,      // Timer terminal pulse level
  output logic o_cold_reset_req,            // Cold reset request pulse
  output logic o_warm_reset_req,            // Warm reset request pulse
  output logic o_power_on_pulse             // Power-on reset pulse request
);

  logic rst_core;
  logic lf_s1_r, lf_s2_r, lf_s3_r;
  logic lf_rise;
  // Power-on-only state
  logic por_pulse_en_r, por_pulse_en_nxt;
  logic warm_sel_r, warm_sel_nxt;
  logic flag_r, flag_nxt;
  // Core state
  logic [5:0] cfg_r, cfg_nxt;
  logic [2:0] exp_r, exp_nxt;
  logic [4:0] pc_r, pc_nxt;
  logic [15:0] trl_r, trl_nxt;
  logic [15:0] tcnt_r, tcnt_nxt;
  logic tc_r, tc_nxt;
  logic rst_r, rst_nxt;
  logic term_r, term_nxt;
  logic [7:0] preset_r, preset_nxt;
  logic [7:0] wcnt_r, wcnt_nxt;
  logic [7:0] ld_r, ld_nxt;
  logic run_r, run_nxt;
  logic pend_r, pend_nxt;
  logic [1:0] guard_r, guard_nxt;
  twu_seq_t seq_r, seq_nxt;
  logic [15:0] rdata_nxt;
  logic cold_nxt, warm_nxt, porp_nxt;
  // Combinational helpers
  logic [4:0] pmask;
  logic pre_tick, wd_tick, event_c, touch_c, seq_done;
  logic wr_cfg, wr_pre, wr_trl, wr_tcs, wr_wrl, wr_svc, rd_tcs;
  logic [7:0] wb;

  assign rst_core = i_reset | i_por_reset;
  assign wb = i_bus.wdata[7:0];
  assign wr_cfg = i_bus.wr && (i_bus.addr == TWU_CFG_ADDR);
  assign wr_pre = i_bus.wr && (i_bus.addr == TWU_PRE_ADDR);
  assign wr_trl = i_bus.wr && (i_bus.addr == TWU_TRL_ADDR);
  assign wr_tcs = i_bus.wr && (i_bus.addr == TWU_TCS_ADDR);
  assign wr_wrl = i_bus.wr && (i_bus.addr == TWU_WRL_ADDR);
  assign wr_svc = i_bus.wr && (i_bus.addr == TWU_SVC_ADDR);
  assign rd_tcs = i_bus.rd && (i_bus.addr == TWU_TCS_ADDR);

  // Synchronise the slow clock pin, edge detect after the second stage
  // No reset here: clearing the stages while the pin is high would fake an edge
  always_ff @(posedge i_mclk) begin
    lf_s1_r <= i_low_freq_clock;
    lf_s2_r <= lf_s1_r;
    lf_s3_r <= lf_s2_r;
  end
  assign lf_rise = lf_s2_r & ~lf_s3_r;

  // Prescaled tick and the selected watchdog tick
  always_comb begin
    pmask = 5'((6'h01 << exp_r) - 6'h01);
    pre_tick = lf_rise && (pc_r == pmask);
    wd_tick = cfg_r[CFG_CLKSEL] ? pre_tick :
      (pre_tick && !rst_r && (tcnt_r == 16'h0000));
  end

  // Next-state logic for every core register
  always_comb begin
    por_pulse_en_nxt = por_pulse_en_r;
    warm_sel_nxt = warm_sel_r;
    flag_nxt = flag_r;
    cfg_nxt = cfg_r;
    exp_nxt = exp_r;
    pc_nxt = pc_r;
    trl_nxt = trl_r;
    tcnt_nxt = tcnt_r;
    tc_nxt = tc_r;
    rst_nxt = rst_r;
    term_nxt = term_r;
    preset_nxt = preset_r;
    wcnt_nxt = wcnt_r;
    ld_nxt = ld_r;
    run_nxt = run_r;
    pend_nxt = pend_r;
    guard_nxt = guard_r;
    seq_nxt = seq_r;
    rdata_nxt = 16'h0000;
    event_c = 1'b0;
    touch_c = 1'b0;
    seq_done = 1'b0;

    // Prescaler counter
    if (lf_rise) begin
      pc_nxt = pre_tick ? 5'h00 : pc_r + 5'h01;
    end

    // Periodic timer
    if (pre_tick) begin
      if (rst_r) begin
        tcnt_nxt = trl_r;
        rst_nxt = 1'b0;
        term_nxt = 1'b0;
      end else if (tcnt_r == 16'h0000) begin
        tcnt_nxt = trl_r;
        term_nxt = 1'b1;
      end else begin
        tcnt_nxt = tcnt_r - 16'h0001;
        term_nxt = 1'b0;
      end
    end
    // Status read clears the terminal flag; a new zero wins
    if (rd_tcs) begin
      tc_nxt = 1'b0;
    end
    if (pre_tick && !rst_r && (tcnt_r == 16'h0000)) begin
      tc_nxt = 1'b1;
    end

    // Early-write guard counts watchdog clocks, saturating
    if (wd_tick && (guard_r != TWU_EARLY_TICKS)) begin
      guard_nxt = guard_r + 2'h1;
    end

    // Watchdog counter runs on its selected clock
    if (run_r && wd_tick) begin
      if (pend_r) begin
        wcnt_nxt = ld_r;
        pend_nxt = 1'b0;
      end else if (wcnt_r <= 8'h01) begin
        wcnt_nxt = 8'h00;
        event_c = 1'b1;
      end else begin
        wcnt_nxt = wcnt_r - 8'h01;
      end
    end

    // Configuration write: upper bits plain, lock bits set only
    if (wr_cfg && !cfg_r[CFG_LK_CFG]) begin
      por_pulse_en_nxt = wb[CFG_POR_PULSE];
      warm_sel_nxt = wb[CFG_WARM];
      cfg_nxt[5:4] = wb[5:4];
      cfg_nxt[3:0] = cfg_r[3:0] | wb[3:0];
    end
    // Prescaler write with exponent limited to its range
    if (wr_pre && !cfg_r[CFG_LK_PRE]) begin
      exp_nxt = (wb[2:0] > TWU_EXP_MAX) ? TWU_EXP_MAX : wb[2:0];
    end
    // Timer reload and control writes
    if (wr_trl && !cfg_r[CFG_LK_TMR]) begin
      trl_nxt = i_bus.wdata;
    end
    if (wr_tcs && !cfg_r[CFG_LK_TMR] && wb[ST_RST]) begin
      rst_nxt = 1'b1;
    end

    // Watchdog reload write: preset update, start or touch
    if (wr_wrl) begin
      if (!cfg_r[CFG_LK_WRL]) begin
        preset_nxt = wb;
      end
      if (guard_r != TWU_EARLY_TICKS) begin
        event_c = 1'b1;
      end
      guard_nxt = 2'h0;
      if (!run_r || !cfg_r[CFG_SME]) begin
        touch_c = 1'b1;
        ld_nxt = cfg_r[CFG_LK_WRL] ? preset_r : wb;
      end
    end

    // Service register: stop/unlock sequence, service byte, wrong data
    if (wr_svc) begin
      seq_nxt = SEQ_IDLE;
      if (wb == TWU_SEQ_B0) begin
        seq_nxt = SEQ_GOT1;
      end else if ((seq_r == SEQ_GOT1) && (wb == TWU_SEQ_B1)) begin
        seq_nxt = SEQ_GOT2;
      end else if ((seq_r == SEQ_GOT2) && (wb == TWU_SEQ_B2)) begin
        seq_done = 1'b1;
      end else if (cfg_r[CFG_SME] && (wb == TWU_SVC_BYTE)) begin
        if (guard_r != TWU_EARLY_TICKS) begin
          event_c = 1'b1;
        end
        guard_nxt = 2'h0;
        touch_c = 1'b1;
        ld_nxt = preset_r;
      end else if (cfg_r[CFG_SME]) begin
        event_c = 1'b1;
      end
      // With match mode off other bytes only return the sequence to idle
    end

    if (touch_c) begin
      run_nxt = 1'b1;
      pend_nxt = 1'b1;
    end
    if (seq_done) begin
      if (run_r) begin
        run_nxt = 1'b0;
        pend_nxt = 1'b0;
      end else begin
        cfg_nxt[3:0] = 4'h0;
      end
    end

    // An event stops the counter and is latched; set wins over clear
    if (wr_tcs && wb[ST_FLAG]) begin
      flag_nxt = 1'b0;
    end
    if (event_c) begin
      flag_nxt = 1'b1;
      run_nxt = 1'b0;
      pend_nxt = 1'b0;
      guard_nxt = TWU_EARLY_TICKS;
    end

    // Register read data, locked CFG, PRE and TRL read as zero
    if (i_bus.rd) begin
      case (i_bus.addr)
        TWU_CFG_ADDR: begin
          if (!cfg_r[CFG_LK_CFG]) begin
            rdata_nxt = {8'h00, por_pulse_en_r, warm_sel_r, cfg_r};
          end
        end
        TWU_PRE_ADDR: begin
          if (!cfg_r[CFG_LK_PRE]) begin
            rdata_nxt = {13'h0000, exp_r};
          end
        end
        TWU_TRL_ADDR: begin
          if (!cfg_r[CFG_LK_TMR]) begin
            rdata_nxt = trl_r;
          end
        end
        TWU_TCS_ADDR: begin
          rdata_nxt = {10'h000, run_r, flag_r, pend_r, 1'b0, tc_r, rst_r};
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end

    // Reset request routing
    cold_nxt = event_c && !warm_sel_r;
    warm_nxt = event_c && warm_sel_r;
    porp_nxt = event_c && !warm_sel_r && por_pulse_en_r;
  end

  // Bits that only power-on reset restores
  always_ff @(posedge i_mclk) begin
    if (i_por_reset) begin
      por_pulse_en_r <= 1'b0;
      warm_sel_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      por_pulse_en_r <= por_pulse_en_nxt;
      warm_sel_r <= warm_sel_nxt;
      flag_r <= flag_nxt;
    end
  end

  // Core domain registers
  always_ff @(posedge i_mclk) begin
    if (rst_core) begin
      cfg_r <= 6'h00;
      exp_r <= 3'h0;
      pc_r <= 5'h00;
      trl_r <= TWU_TRL_RESET;
      tcnt_r <= TWU_TRL_RESET;
      tc_r <= 1'b0;
      rst_r <= 1'b0;
      term_r <= 1'b0;
      preset_r <= TWU_WRL_RESET;
      wcnt_r <= TWU_WRL_RESET;
      ld_r <= TWU_WRL_RESET;
      run_r <= 1'b0;
      pend_r <= 1'b0;
      guard_r <= TWU_EARLY_TICKS;
      seq_r <= SEQ_IDLE;
      o_rdata <= 16'h0000;
      o_cold_reset_req <= 1'b0;
      o_warm_reset_req <= 1'b0;
      o_power_on_pulse <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      exp_r <= exp_nxt;
      pc_r <= pc_nxt;
      trl_r <= trl_nxt;
      tcnt_r <= tcnt_nxt;
      tc_r <= tc_nxt;
      rst_r <= rst_nxt;
      term_r <= term_nxt;
      preset_r <= preset_nxt;
      wcnt_r <= wcnt_nxt;
      ld_r <= ld_nxt;
      run_r <= run_nxt;
      pend_r <= pend_nxt;
      guard_r <= guard_nxt;
      seq_r <= seq_nxt;
      o_rdata <= rdata_nxt;
      o_cold_reset_req <= cold_nxt;
      o_warm_reset_req <= warm_nxt;
      o_power_on_pulse <= porp_nxt;
    end
  end
  assign o_timer_terminal_pulse = term_r;

  // Checks on the documented behaviour
  a_por_only_cold: assert property (@(posedge i_mclk) disable iff (rst_core)
    o_power_on_pulse |-> (o_cold_reset_req && !o_warm_reset_req))
    else $error("power-on pulse without cold reset");
  a_mode_route: assert property (@(posedge i_mclk) disable iff (rst_core)
    (o_warm_reset_req || o_cold_reset_req) |-> (o_warm_reset_req == $past(warm_sel_r)))
    else $error("reset request routed to wrong type");
  a_lock_sticky: assert property (@(posedge i_mclk) disable iff (rst_core)
    !seq_done |=> ((cfg_r[3:0] & $past(cfg_r[3:0])) == $past(cfg_r[3:0])))
    else $error("lock bit fell without unlock");
  a_reload_locked: assert property (@(posedge i_mclk) disable iff (rst_core)
    (wr_wrl && cfg_r[CFG_LK_WRL]) |=> (preset_r == $past(preset_r)))
    else $error("locked reload changed");
  a_cfg_locked: assert property (@(posedge i_mclk) disable iff (rst_core)
    (wr_cfg && cfg_r[CFG_LK_CFG] && !seq_done) |=> $stable(cfg_r))
    else $error("locked config changed");
  a_pre_locked: assert property (@(posedge i_mclk) disable iff (rst_core)
    (wr_pre && cfg_r[CFG_LK_PRE]) |=> $stable(exp_r))
    else $error("locked prescaler changed");
  a_tc_read_clr: assert property (@(posedge i_mclk) disable iff (rst_core)
    (rd_tcs && !(pre_tick && !rst_r && tcnt_r == 16'h0000)) |=> !tc_r)
    else $error("terminal flag survived read");
  a_flag_holds: assert property (@(posedge i_mclk) disable iff (i_por_reset)
    (flag_r && !(wr_tcs && wb[ST_FLAG])) |=> flag_r)
    else $error("event flag lost");
  a_early_write: assert property (@(posedge i_mclk) disable iff (rst_core)
    (wr_wrl && !event_c) ##1 (!wr_wrl && !event_c) [*3] ##1 wr_wrl
      |=> (o_cold_reset_req || o_warm_reset_req))
    else $error("early reload write missed");
  a_start_run: assert property (@(posedge i_mclk) disable iff (rst_core)
    (!run_r && wr_wrl && guard_r == TWU_EARLY_TICKS) |=> (run_r && pend_r))
    else $error("reload write did not start watchdog");
  a_rst_clear: assert property (@(posedge i_mclk) disable iff (rst_core)
    (rst_r && pre_tick && !wr_tcs) |=> (!rst_r && tcnt_r == $past(trl_r)))
    else $error("forced reload failed");

endmodule // timer_watchdog_unit

//--- twu_pkg.sv
// Package: register map, field positions, reset values and bus carrier for the timer watchdog
package twu_pkg;
  localparam int TWU_AW = 24;
  localparam logic [23:0] TWU_CFG_ADDR = 24'hfff4c0;
  localparam logic [23:0] TWU_PRE_ADDR = 24'hfff4c2;
  localparam logic [23:0] TWU_TRL_ADDR = 24'hfff4c4;
  localparam logic [23:0] TWU_TCS_ADDR = 24'hfff4c6;
  localparam logic [23:0] TWU_WRL_ADDR = 24'hfff4c8;
  localparam logic [23:0] TWU_SVC_ADDR = 24'hfff4ca;
  // Configuration bit positions
  localparam int CFG_POR_PULSE = 7;
  localparam int CFG_WARM = 6;
  localparam int CFG_SME = 5;
  localparam int CFG_CLKSEL = 4;
  localparam int CFG_LK_WRL = 3;
  localparam int CFG_LK_TMR = 2;
  localparam int CFG_LK_PRE = 1;
  localparam int CFG_LK_CFG = 0;
  // Status bit positions
  localparam int ST_RUN = 5;
  localparam int ST_FLAG = 4;
  localparam int ST_PEND = 3;
  localparam int ST_TC = 1;
  localparam int ST_RST = 0;
  // Reset values, limits and magic bytes
  localparam logic [7:0] TWU_WRL_RESET = 8'h0f;
  localparam logic [15:0] TWU_TRL_RESET = 16'hffff;
  localparam logic [2:0] TWU_EXP_MAX = 3'h5;
  localparam logic [7:0] TWU_SVC_BYTE = 8'h5c;
  localparam logic [7:0] TWU_SEQ_B0 = 8'h87;
  localparam logic [7:0] TWU_SEQ_B1 = 8'h61;
  localparam logic [7:0] TWU_SEQ_B2 = 8'h63;
  localparam logic [1:0] TWU_EARLY_TICKS = 2'h3;
  // Sequence recogniser states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_GOT1, SEQ_GOT2} twu_seq_t;
  // Register bus request
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } twu_bus_req_t;
endpackage

//--- tb.sv
// Self-checking testbench for the timer watchdog unit
`timescale 1ns/1ns
module tb;
  import twu_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic i_por_reset = 1'b1;
  logic i_low_freq_clock = 1'b0;
  twu_bus_req_t bus = '0;
  logic [15:0] o_rdata;
  logic tp, cold, warm, pon;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  time t0;

  // System clock; a free-running fast stand-in for the slow pin keeps the run short
  always #5 i_mclk = ~i_mclk;
  always #43 i_low_freq_clock = ~i_low_freq_clock;

  timer_watchdog_unit uut (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_por_reset(i_por_reset),
    .i_low_freq_clock(i_low_freq_clock),
    .i_bus(bus),
    .o_rdata(o_rdata),
    .o_timer_terminal_pulse(tp),
    .o_cold_reset_req(cold),
    .o_warm_reset_req(warm),
    .o_power_on_pulse(pon)
  );

  // Comparison and reporting
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Closing report, also reached when the run hangs
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask

  // Read with a mask; data is looked at in the cycle after the strobe
  task automatic rdm(input logic [23:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    #1 chk(o_rdata & m, exp);
  endtask

  task automatic rdc(input logic [23:0] a, input logic [15:0] exp);
    rdm(a, 16'hffff, exp);
  endtask

  task automatic sv(input logic [7:0] b);
    wr(TWU_SVC_ADDR, {8'h00, b});
  endtask

  task automatic unlock;
    sv(TWU_SEQ_B0);
    sv(TWU_SEQ_B1);
    sv(TWU_SEQ_B2);
  endtask

  // Waits a bounded number of cycles for a reset request pulse
  task automatic wait_evt(input int lim, output int k);
    k = 0;
    #1; // A pulse launched on the strobe's own edge is visible only after it
    while (k < lim && !(cold === 1'b1 || warm === 1'b1)) begin
      @(posedge i_mclk);
      #1 k++;
    end
  endtask

  task automatic rst(input logic por);
    @(posedge i_mclk);
    i_reset <= 1'b1;
    i_por_reset <= por;
    repeat (3) @(posedge i_mclk);
    i_reset <= 1'b0;
    i_por_reset <= 1'b0;
  endtask

  task automatic t_reset;
    rdc(TWU_CFG_ADDR, 16'h0000);
    rdc(TWU_TCS_ADDR, 16'h0000);
    rdc(TWU_PRE_ADDR, 16'h0000);
    rdc(TWU_TRL_ADDR, TWU_TRL_RESET);
    rdc(TWU_WRL_ADDR, 16'h0000);
    rdc(24'hfff4cc, 16'h0000);
  endtask

  task automatic t_locks;
    wr(TWU_PRE_ADDR, 16'h0007);
    rdc(TWU_PRE_ADDR, 16'h0005);
    wr(TWU_CFG_ADDR, 16'h0002);
    wr(TWU_CFG_ADDR, 16'h0000);
    rdc(TWU_CFG_ADDR, 16'h0002);
    wr(TWU_PRE_ADDR, 16'h0001);
    rdc(TWU_PRE_ADDR, 16'h0000);
    unlock();
    rdc(TWU_CFG_ADDR, 16'h0000);
    rdc(TWU_PRE_ADDR, 16'h0005);
    wr(TWU_CFG_ADDR, 16'h0005);
    wr(TWU_CFG_ADDR, 16'h0010);
    wr(TWU_TRL_ADDR, 16'h0003);
    rdc(TWU_TRL_ADDR, 16'h0000);
    unlock();
    rdc(TWU_CFG_ADDR, 16'h0000);
    rdc(TWU_TRL_ADDR, TWU_TRL_RESET);
    wr(TWU_PRE_ADDR, 16'h0000);
  endtask

  // Timer clock source with a huge period: the watchdog never ticks
  task automatic t_early;
    wr(TWU_CFG_ADDR, 16'h00c0);
    wr(TWU_WRL_ADDR, 16'h0020);
    rdc(TWU_TCS_ADDR, 16'h0028);
    wr(TWU_WRL_ADDR, 16'h0020);
    wait_evt(10, n);
    chk({13'h0, cold, warm, pon}, 16'h0002);
    rdm(TWU_TCS_ADDR, 16'h0030, 16'h0010);
    wr(TWU_TCS_ADDR, 16'h0000);
    rdm(TWU_TCS_ADDR, 16'h0010, 16'h0010);
    wr(TWU_TCS_ADDR, 16'h0010);
    rdm(TWU_TCS_ADDR, 16'h0010, 16'h0000);
  endtask

  task automatic t_late;
    rst(1'b0);
    rdc(TWU_CFG_ADDR, 16'h00c0);
    wr(TWU_CFG_ADDR, 16'h0090);
    wr(TWU_WRL_ADDR, 16'h0004);
    wait_evt(200, n);
    chk({13'h0, cold, warm, pon}, 16'h0005);
    chk(16'(n > 20 && n < 100), 16'h0001);
    rst(1'b0);
    rdm(TWU_TCS_ADDR, 16'h0030, 16'h0010);
    rst(1'b1);
    rdc(TWU_TCS_ADDR, 16'h0000);
    rdc(TWU_CFG_ADDR, 16'h0000);
  endtask

  task automatic t_match;
    wr(TWU_CFG_ADDR, 16'h0010);
    sv(8'h11);
    wait_evt(10, n);
    chk(16'(n), 16'd10);
    rdm(TWU_TCS_ADDR, 16'h0020, 16'h0000);
    wr(TWU_CFG_ADDR, 16'h0030);
    sv(TWU_SVC_BYTE);
    repeat (60) @(posedge i_mclk);
    rdm(TWU_TCS_ADDR, 16'h0020, 16'h0020);
    sv(TWU_SVC_BYTE);
    wait_evt(10, n);
    chk(16'(n), 16'd10);
    sv(8'h11);
    wait_evt(10, n);
    chk({13'h0, cold, warm, pon}, 16'h0004);
    rdm(TWU_TCS_ADDR, 16'h0020, 16'h0000);
    sv(TWU_SVC_BYTE);
    sv(TWU_SVC_BYTE);
    wait_evt(10, n);
    chk({13'h0, cold, warm, pon}, 16'h0004);
  endtask

  task automatic t_stop;
    wr(TWU_CFG_ADDR, 16'h0000);
    wr(TWU_WRL_ADDR, 16'h0020);
    wr(TWU_CFG_ADDR, 16'h0008);
    sv(TWU_SEQ_B0);
    sv(8'h11);
    sv(TWU_SEQ_B1);
    sv(TWU_SEQ_B2);
    rdm(TWU_TCS_ADDR, 16'h0020, 16'h0020);
    unlock();
    rdm(TWU_TCS_ADDR, 16'h0020, 16'h0000);
    wr(TWU_WRL_ADDR, 16'h0001);
    wait_evt(10, n);
    chk({13'h0, cold, warm, pon}, 16'h0004);
    rdc(TWU_CFG_ADDR, 16'h0008);
    unlock();
    rdc(TWU_CFG_ADDR, 16'h0000);
  endtask

  // Reload 3 gives a period of four prescaled ticks of 86 ns
  task automatic t_timer;
    wr(TWU_TRL_ADDR, 16'h0003);
    wr(TWU_TCS_ADDR, 16'h0001);
    repeat (30) @(posedge i_mclk);
    rdm(TWU_TCS_ADDR, 16'h0001, 16'h0000);
    @(posedge tp);
    t0 = $time;
    @(posedge tp);
    chk(16'(($time - t0) > 330 && ($time - t0) < 360), 16'h0001);
    rdm(TWU_TCS_ADDR, 16'h0002, 16'h0002);
    rdm(TWU_TCS_ADDR, 16'h0002, 16'h0000);
  endtask

  // Cuts a hung run short
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge i_mclk);
    i_reset <= 1'b0;
    i_por_reset <= 1'b0;
    t_reset();
    t_locks();
    t_early();
    t_late();
    t_match();
    t_stop();
    t_timer();
    give_verdict();
  end
endmodule // tb
